/* File: verilog/pcs_regs_pkg.sv */
// constants shared by the coding sublayer control and status bank
package pcs_regs_pkg;

    // printed offsets carry the space nibble in bits 15:12
    localparam logic [15:0] CTRL_ALIAS_OFS = 16'h3000;
    localparam logic [15:0] CTRL_OFS       = 16'h3900;
    localparam logic [15:0] STATUS1_OFS    = 16'h3901;
    localparam logic [15:0] STATUS2_OFS    = 16'h3902;
    localparam logic [15:0] SPACE_MASK     = 16'h0fff;

    // register indices seen on the bus, byte address = 4 * index
    localparam int unsigned IDX_W          = 12;
    localparam int unsigned PADDR_W        = 14;
    localparam logic [11:0] CTRL_ALIAS_IDX = 12'h000;
    localparam logic [11:0] CTRL_IDX       = 12'h900;
    localparam logic [11:0] STATUS1_IDX    = 12'h901;
    localparam logic [11:0] STATUS2_IDX    = 12'h902;
    localparam logic [11:0] IRQ_STAT_IDX   = 12'hf00;
    localparam logic [11:0] IRQ_MASK_IDX   = 12'hf01;

    // reset values
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam logic [5:0]  IRQ_RESET      = 6'h00;

    // control fields
    localparam int unsigned CTRL_RESET_BIT = 15;
    localparam int unsigned CTRL_LOOP_BIT  = 14;

    // first status register fields
    localparam int unsigned ST1_TX_LH      = 11;
    localparam int unsigned ST1_RX_LH      = 10;
    localparam int unsigned ST1_TX_LIVE    = 9;
    localparam int unsigned ST1_RX_LIVE    = 8;
    localparam int unsigned ST1_FAULT      = 7;
    localparam int unsigned ST1_LINK_LL    = 2;

    // second status register fields
    localparam int unsigned ST2_LINK       = 10;
    localparam int unsigned ST2_HIBER      = 9;
    localparam int unsigned ST2_LOCK       = 8;
    localparam int unsigned ST2_HIBER_LH   = 7;
    localparam int unsigned ST2_LOCK_LL    = 6;

    // live input vector order, also the interrupt bit order
    localparam int unsigned LIVE_W         = 6;
    localparam int unsigned LV_TX_LPI      = 0;
    localparam int unsigned LV_RX_LPI      = 1;
    localparam int unsigned LV_FAULT       = 2;
    localparam int unsigned LV_LINK        = 3;
    localparam int unsigned LV_HIBER       = 4;
    localparam int unsigned LV_LOCK        = 5;
    // events on falling edge rather than rising
    localparam logic [5:0]  IRQ_ON_FALL    = 6'h28;

    // latched bits: source, position, register, polarity
    localparam int unsigned LAT_N          = 5;
    localparam int unsigned LAT_SRC [5]    = '{0, 1, 3, 4, 5};
    localparam int unsigned LAT_POS [5]    = '{11, 10, 2, 7, 6};
    localparam logic [4:0]  LAT_IN_ST2     = 5'h18;
    localparam logic [4:0]  LAT_LOW        = 5'h14;

endpackage

/* File: verilog/pin_sync.sv */
// two-stage synchroniser for a vector of level inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    always_comb begin
        st_d.meta = din;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.sync;
endmodule
`default_nettype wire

/* File: verilog/latch_bit.sv */
// one latched status bit, latching high or latching low
`timescale 1ns/1ps
`default_nettype none
module latch_bit #(
    parameter bit LOW = 1'b0
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // live condition and re-arm
    input  wire logic live,
    input  wire logic clr,
    output logic      q
);
    typedef struct packed {
        logic held;
    } lat_t;

    lat_t st_q;
    lat_t st_d;

    // re-arm loads the live value, so an event still present survives it
    always_comb begin
        if (clr) begin
            st_d.held = live;
        end else if (LOW) begin
            st_d.held = st_q.held & live;
        end else begin
            st_d.held = st_q.held | live;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.held;
endmodule
`default_nettype wire

/* File: verilog/pcs_control_status_regs.sv */
// apb register bank for coding sublayer control, status and interrupts
//
// Summary of operation
// R1 - writing one to control bit 15 resets the sublayer; bit clears itself
// R2 - control bit 14 is writable and enables sublayer loopback when one
// R3 - host drops the leading space nibble; low twelve bits form the index
// R4 - status bit 11 latches high once transmit side saw low-power idle
// R5 - status bit 10 latches high once receive side saw low-power idle
// R6 - status bit 9 reads live transmit low-power idle activity
// R7 - status bit 8 reads live receive low-power idle activity
// R8 - status bit 7 reads the live fault condition
// R9 - status bit 2 latches low on any loss of receive link
// R10 - second status bit 10 reads live receive link state
// R11 - second status bit 9 reads live high error rate report
// R12 - second status bit 8 reads live block lock
// R13 - second status bit 7 latches high once high error rate reported
// R14 - second status bit 6 latches low whenever block lock is lost
// R15 - reading a latched bit re-arms it to the present live condition
// R16 - alias control register bits behave like the main control bits
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pcs_control_status_regs (
    // clock and reset
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [pcs_regs_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // live conditions from the sublayer datapath
    input  wire logic                               tx_lpi_active,
    input  wire logic                               rx_lpi_active,
    input  wire logic                               sublayer_fault,
    input  wire logic                               rx_link_up,
    input  wire logic                               high_error_rate_live,
    input  wire logic                               rx_block_aligned,
    // controls to the sublayer and the interrupt request
    output logic                                    sublayer_reset,
    output logic                                    sublayer_loopback_en,
    output logic                                    irq
);
    typedef struct packed {
        logic        rst;
        logic        loop;
        logic [5:0]  ist;
        logic [5:0]  imask;
        logic [5:0]  prev;
        logic        ready;
        logic        err;
        logic [15:0] rdata;
        logic        irq;
    } state_t;

    state_t                                  st_q;
    state_t                                  st_d;
    logic   [pcs_regs_pkg::LIVE_W-1:0]       live_raw;
    logic   [pcs_regs_pkg::LIVE_W-1:0]       live;
    logic   [pcs_regs_pkg::LAT_N-1:0]        lat_q;
    logic   [pcs_regs_pkg::LAT_N-1:0]        lat_clr;
    logic   [11:0]                           idx;
    logic                                    access;
    logic                                    done;
    logic                                    rd_done;
    logic                                    wr_done;
    logic   [5:0]                            events;
    logic   [15:0]                           st1_word;
    logic   [15:0]                           st2_word;

    // true when the bus index selects the register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    // any mapped index
    function automatic logic mapped(input logic [11:0] a);
        return hit(a, pcs_regs_pkg::CTRL_ALIAS_IDX) || hit(a, pcs_regs_pkg::CTRL_IDX)
            || hit(a, pcs_regs_pkg::STATUS1_IDX) || hit(a, pcs_regs_pkg::STATUS2_IDX)
            || hit(a, pcs_regs_pkg::IRQ_STAT_IDX) || hit(a, pcs_regs_pkg::IRQ_MASK_IDX);
    endfunction

    // either control address reaches the shared control bits
    function automatic logic ctrl_sel(input logic [11:0] a);
        return hit(a, pcs_regs_pkg::CTRL_IDX) || hit(a, pcs_regs_pkg::CTRL_ALIAS_IDX);
    endfunction

    // datapath levels are not assumed to share pclk
    assign live_raw = {rx_block_aligned, high_error_rate_live, rx_link_up,
                       sublayer_fault, rx_lpi_active, tx_lpi_active};

    pin_sync #(
        .W (pcs_regs_pkg::LIVE_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (live_raw),
        .dout    (live)
    );

    // word index with the space nibble already dropped by the host
    assign idx     = paddr[pcs_regs_pkg::PADDR_W-1:2]; // R3
    // one wait state: first access cycle computes, second completes
    assign access  = psel & penable & ~st_q.ready;
    assign done    = psel & penable & st_q.ready;
    assign rd_done = done & ~pwrite;
    assign wr_done = done & pwrite;

    genvar g;
    generate
        for (g = 0; g < pcs_regs_pkg::LAT_N; g++) begin : g_lat
            localparam logic [11:0] REG_IDX = pcs_regs_pkg::LAT_IN_ST2[g]
                ? pcs_regs_pkg::STATUS2_IDX : pcs_regs_pkg::STATUS1_IDX;
            // read or written zero re-arms in the access cycle, so no event there is lost
            assign lat_clr[g] = hit(idx, REG_IDX) & access
                & (~pwrite | ~pwdata[pcs_regs_pkg::LAT_POS[g]]); // R15
            latch_bit #(
                .LOW (pcs_regs_pkg::LAT_LOW[g])
            ) u_lat (
                .pclk    (pclk),
                .presetn (presetn),
                .live    (live[pcs_regs_pkg::LAT_SRC[g]]),
                .clr     (lat_clr[g]),
                .q       (lat_q[g])
            ); // R4 R5 R9 R13 R14
        end
    endgenerate

    // rising edges of activity, falling edges of link and lock
    assign events = (live ^ st_q.prev) & (live ^ pcs_regs_pkg::IRQ_ON_FALL);

    always_comb begin
        st1_word = pcs_regs_pkg::REG_RESET;
        st1_word[pcs_regs_pkg::ST1_TX_LH]   = lat_q[0]; // R4
        st1_word[pcs_regs_pkg::ST1_RX_LH]   = lat_q[1]; // R5
        st1_word[pcs_regs_pkg::ST1_TX_LIVE] = live[pcs_regs_pkg::LV_TX_LPI]; // R6
        st1_word[pcs_regs_pkg::ST1_RX_LIVE] = live[pcs_regs_pkg::LV_RX_LPI]; // R7
        st1_word[pcs_regs_pkg::ST1_FAULT]   = live[pcs_regs_pkg::LV_FAULT]; // R8
        st1_word[pcs_regs_pkg::ST1_LINK_LL] = lat_q[2]; // R9
        st2_word = pcs_regs_pkg::REG_RESET;
        st2_word[pcs_regs_pkg::ST2_LINK]     = live[pcs_regs_pkg::LV_LINK]; // R10
        st2_word[pcs_regs_pkg::ST2_HIBER]    = live[pcs_regs_pkg::LV_HIBER]; // R11
        st2_word[pcs_regs_pkg::ST2_LOCK]     = live[pcs_regs_pkg::LV_LOCK]; // R12
        st2_word[pcs_regs_pkg::ST2_HIBER_LH] = lat_q[3]; // R13
        st2_word[pcs_regs_pkg::ST2_LOCK_LL]  = lat_q[4]; // R14
    end

    always_comb begin
        st_d       = st_q;
        st_d.prev  = live;
        st_d.ready = access;
        st_d.err   = 1'b0;
        // reset request lives for one cycle only
        st_d.rst   = 1'b0; // R1
        if (access) begin
            st_d.err   = ~mapped(idx);
            st_d.rdata = pcs_regs_pkg::REG_RESET;
            if (!pwrite) begin
                if (ctrl_sel(idx)) begin
                    st_d.rdata[pcs_regs_pkg::CTRL_RESET_BIT] = st_q.rst; // R16
                    st_d.rdata[pcs_regs_pkg::CTRL_LOOP_BIT]  = st_q.loop; // R16
                end
                if (hit(idx, pcs_regs_pkg::STATUS1_IDX)) begin
                    st_d.rdata = st1_word;
                end
                if (hit(idx, pcs_regs_pkg::STATUS2_IDX)) begin
                    st_d.rdata = st2_word;
                end
                if (hit(idx, pcs_regs_pkg::IRQ_STAT_IDX)) begin
                    st_d.rdata[5:0] = st_q.ist;
                end
                if (hit(idx, pcs_regs_pkg::IRQ_MASK_IDX)) begin
                    st_d.rdata[5:0] = st_q.imask;
                end
            end
        end
        if (wr_done) begin
            // both addresses steer the same two control bits
            if (ctrl_sel(idx)) begin
                st_d.rst  = pwdata[pcs_regs_pkg::CTRL_RESET_BIT]; // R1 R16
                st_d.loop = pwdata[pcs_regs_pkg::CTRL_LOOP_BIT]; // R2 R16
            end
            if (hit(idx, pcs_regs_pkg::IRQ_STAT_IDX)) begin
                st_d.ist = st_q.ist & ~pwdata[5:0];
            end
            if (hit(idx, pcs_regs_pkg::IRQ_MASK_IDX)) begin
                st_d.imask = pwdata[5:0];
            end
        end
        // an event in the clearing cycle is kept
        st_d.ist = st_d.ist | events;
        st_d.irq = |(st_d.ist & st_d.imask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= '0;
            st_q.ist   <= pcs_regs_pkg::IRQ_RESET;
            st_q.imask <= pcs_regs_pkg::IRQ_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata               = {16'h0000, st_q.rdata};
    assign pready               = st_q.ready;
    assign pslverr              = st_q.err;
    assign sublayer_reset       = st_q.rst;
    assign sublayer_loopback_en = st_q.loop;
    assign irq                  = st_q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_wr;
        wr_done && (hit(idx, pcs_regs_pkg::CTRL_IDX));
    endsequence

    sequence s_alias_wr;
        wr_done && (hit(idx, pcs_regs_pkg::CTRL_ALIAS_IDX));
    endsequence

    sequence s_rd_st1;
        rd_done && hit(idx, pcs_regs_pkg::STATUS1_IDX);
    endsequence

    sequence s_rd_st2;
        rd_done && hit(idx, pcs_regs_pkg::STATUS2_IDX);
    endsequence

    sequence s_access;
        psel && penable && !pready;
    endsequence

    sequence s_wr0_st2;
        access && pwrite && hit(idx, pcs_regs_pkg::STATUS2_IDX)
            && !pwdata[pcs_regs_pkg::ST2_HIBER_LH];
    endsequence

    property p_reset_pulse;
        s_ctrl_wr ##0 pwdata[15] |=> sublayer_reset ##1 !sublayer_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset bit not one-cycle"); // R1

    property p_loop_wr;
        s_ctrl_wr |=> sublayer_loopback_en == $past(pwdata[14]);
    endproperty
    a_loop_wr: assert property (p_loop_wr) else $error("loopback not written"); // R2

    property p_alias_ctrl;
        s_alias_wr |=> sublayer_loopback_en == $past(pwdata[14])
            && sublayer_reset == $past(pwdata[15]);
    endproperty
    a_alias_ctrl: assert property (p_alias_ctrl) else $error("alias write differs"); // R16

    property p_tx_lh;
        live[0] |=> lat_q[0];
    endproperty
    a_tx_lh: assert property (p_tx_lh) else $error("tx idle latch missed"); // R4

    property p_rx_lh;
        live[1] |=> lat_q[1];
    endproperty
    a_rx_lh: assert property (p_rx_lh) else $error("rx idle latch missed"); // R5

    property p_link_ll;
        !live[3] |=> !lat_q[2];
    endproperty
    a_link_ll: assert property (p_link_ll) else $error("link loss not latched"); // R9

    property p_hiber_lh;
        live[4] |=> lat_q[3];
    endproperty
    a_hiber_lh: assert property (p_hiber_lh) else $error("high error latch missed"); // R13

    property p_lock_ll;
        !live[5] |=> !lat_q[4];
    endproperty
    a_lock_ll: assert property (p_lock_ll) else $error("lock loss not latched"); // R14

    property p_rearm;
        s_rd_st1 |-> lat_q[0] == $past(live[0]) && lat_q[2] == $past(live[3]);
    endproperty
    a_rearm: assert property (p_rearm) else $error("read did not re-arm"); // R15

    property p_live_st1;
        s_rd_st1 |-> prdata[9] == $past(live[0]) && prdata[8] == $past(live[1])
            && prdata[7] == $past(live[2]);
    endproperty
    a_live_st1: assert property (p_live_st1) else $error("live status wrong"); // R6 R7 R8

    property p_live_st2;
        s_rd_st2 |-> prdata[10] == $past(live[3])
            && prdata[9] == $past(live[4]) && prdata[8] == $past(live[5]);
    endproperty
    a_live_st2: assert property (p_live_st2) else $error("second status wrong"); // R10 R11 R12

    property p_decode;
        done |-> pslverr == !mapped(paddr[13:2]);
    endproperty
    a_decode: assert property (p_decode) else $error("index decode wrong"); // R3

    property p_one_wait;
        s_access |=> pready ##1 !pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not one wait state"); // R3

    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error outside ready"); // R3

    property p_rst_clear;
        !(wr_done && ctrl_sel(idx)) |=> !sublayer_reset;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset without write"); // R1 R16

    property p_loop_hold;
        !(wr_done && ctrl_sel(idx)) |=> $stable(sublayer_loopback_en);
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("loopback changed alone"); // R2

    property p_tx_hold;
        lat_q[0] && !lat_clr[0] |=> lat_q[0];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx idle latch dropped"); // R4

    property p_link_hold;
        !lat_q[2] && !lat_clr[2] |=> !lat_q[2];
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("link latch rose alone"); // R9

    property p_hiber_hold;
        lat_q[3] && !lat_clr[3] |=> lat_q[3];
    endproperty
    a_hiber_hold: assert property (p_hiber_hold) else $error("error latch dropped"); // R13

    property p_lock_hold;
        !lat_q[4] && !lat_clr[4] |=> !lat_q[4];
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock latch rose alone"); // R14

    property p_wr0_rearm;
        s_wr0_st2 |=> lat_q[3] == $past(live[4]);
    endproperty
    a_wr0_rearm: assert property (p_wr0_rearm) else $error("zero write no re-arm"); // R15

    property p_rearm2;
        s_rd_st2 |-> lat_q[3] == $past(live[4]) && lat_q[4] == $past(live[5]);
    endproperty
    a_rearm2: assert property (p_rearm2) else $error("second read no re-arm"); // R15

    property p_ist_event;
        |events |=> (st_q.ist & $past(events)) == $past(events);
    endproperty
    a_ist_event: assert property (p_ist_event) else $error("status event lost");
endmodule
`default_nettype wire

/* File: sim/pcs_control_status_regs_test.sv */
// self-checking bench for the coding sublayer control and status bank
`timescale 1ns/1ps
`default_nettype none
module pcs_control_status_regs_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  lv;
    logic        sublayer_reset;
    logic        sublayer_loopback_en;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    integer      seed;
    int          err_total;
    int          checks_done;
    int          cyc;
    logic [15:0] ofs_list [6];

    pcs_control_status_regs u_pcs_control_status_regs (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .tx_lpi_active        (lv[pcs_regs_pkg::LV_TX_LPI]),
        .rx_lpi_active        (lv[pcs_regs_pkg::LV_RX_LPI]),
        .sublayer_fault       (lv[pcs_regs_pkg::LV_FAULT]),
        .rx_link_up           (lv[pcs_regs_pkg::LV_LINK]),
        .high_error_rate_live (lv[pcs_regs_pkg::LV_HIBER]),
        .rx_block_aligned     (lv[pcs_regs_pkg::LV_LOCK]),
        .sublayer_reset       (sublayer_reset),
        .sublayer_loopback_en (sublayer_loopback_en),
        .irq                  (irq)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, well above the fewer than a thousand cycles the sequence needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // host drops the space nibble; byte address is four times the index
    task automatic apb(input logic wr, input logic [15:0] ofs, input logic [15:0] wd,
                       output logic [31:0] rdat, output logic err);
        logic [15:0] ix;
        ix = ofs & pcs_regs_pkg::SPACE_MASK;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {ix[11:0], 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] ofs, input logic [31:0] exp);
        apb(1'b0, ofs, 16'h0000, rd, er);
        chk({31'h0, er}, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] live1(input logic [5:0] v);
        return (32'(v[pcs_regs_pkg::LV_TX_LPI]) << pcs_regs_pkg::ST1_TX_LIVE)
             | (32'(v[pcs_regs_pkg::LV_RX_LPI]) << pcs_regs_pkg::ST1_RX_LIVE)
             | (32'(v[pcs_regs_pkg::LV_FAULT]) << pcs_regs_pkg::ST1_FAULT);
    endfunction

    function automatic logic [31:0] live2(input logic [5:0] v);
        return (32'(v[pcs_regs_pkg::LV_LINK]) << pcs_regs_pkg::ST2_LINK)
             | (32'(v[pcs_regs_pkg::LV_HIBER]) << pcs_regs_pkg::ST2_HIBER)
             | (32'(v[pcs_regs_pkg::LV_LOCK]) << pcs_regs_pkg::ST2_LOCK);
    endfunction

    initial begin
        seed = 41980;
        err_total = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
        lv = 6'h00;
        ofs_list = '{16'h3000, 16'h3900, 16'h3901, 16'h3902, 16'h3f00, 16'h3f01};
        wt(16);
        presetn <= 1'b1;
        foreach (ofs_list[i]) rchk(ofs_list[i], 32'h0);
        // unmapped index is refused and has no effect
        apb(1'b1, 16'h3123, 16'hffff, rd, er);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 16'h3123, 16'h0000, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // self-clearing reset through main and alias addresses
        apb(1'b1, pcs_regs_pkg::CTRL_OFS, 16'h8000, rd, er);
        #1 chk({31'h0, sublayer_reset}, 32'h1);
        @(posedge pclk);
        #1 chk({31'h0, sublayer_reset}, 32'h0);
        rchk(pcs_regs_pkg::CTRL_OFS, 32'h0);
        apb(1'b1, pcs_regs_pkg::CTRL_OFS, 16'h4000, rd, er);
        #1 chk({31'h0, sublayer_loopback_en}, 32'h1);
        rchk(pcs_regs_pkg::CTRL_ALIAS_OFS, 32'h4000);
        apb(1'b1, pcs_regs_pkg::CTRL_ALIAS_OFS, 16'h8000, rd, er);
        #1 chk({30'h0, sublayer_reset, sublayer_loopback_en}, 32'h2);
        rchk(pcs_regs_pkg::CTRL_OFS, 32'h0);
        // latch-low bits stay low after reset until a read re-arms them
        lv <= 6'h28;
        wt(5);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'h000);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'h004);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h500);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h540);
        lv <= 6'h00;
        wt(3);
        lv <= 6'h28;
        wt(5);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'h000);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'h004);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h500);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h540);
        // latch-high bits survive the end of the event until read
        lv <= 6'h3b;
        wt(5);
        lv <= 6'h28;
        wt(5);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'hc04);
        rchk(pcs_regs_pkg::STATUS1_OFS, 32'h004);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h5c0);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h540);
        // a zero written to a latched bit re-arms it like a read
        lv <= 6'h3b;
        wt(5);
        lv <= 6'h28;
        wt(5);
        apb(1'b1, pcs_regs_pkg::STATUS2_OFS, 16'h0000, rd, er);
        chk({31'h0, er}, 32'h0);
        rchk(pcs_regs_pkg::STATUS2_OFS, 32'h540);
        // idle, error rises and link, lock falls so far
        rchk(16'h3f00, 32'h3b);
        // fault rise raises irq only while unmasked
        apb(1'b1, 16'h3f00, 16'h003f, rd, er);
        apb(1'b1, 16'h3f01, 16'h0004, rd, er);
        wt(3);
        chk({31'h0, irq}, 32'h0);
        lv <= 6'h2c;
        wt(6);
        chk({31'h0, irq}, 32'h1);
        rchk(16'h3f00, 32'h4);
        apb(1'b1, 16'h3f00, 16'h0004, rd, er);
        wt(3);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 16'h3f01, 16'h0000, rd, er);
        lv <= 6'h28;
        wt(3);
        lv <= 6'h2c;
        wt(6);
        chk({31'h0, irq}, 32'h0);
        rchk(16'h3f00, 32'h4);
        apb(1'b1, 16'h3f00, 16'h003f, rd, er);
        // random live levels read back through both status registers
        repeat (40) begin
            lv <= 6'($random(seed));
            wt(5);
            apb(1'b0, pcs_regs_pkg::STATUS1_OFS, 16'h0000, rd, er);
            chk(rd & 32'h380, live1(lv));
            apb(1'b0, pcs_regs_pkg::STATUS2_OFS, 16'h0000, rd, er);
            chk(rd & 32'h700, live2(lv));
        end
        final_report();
    end
endmodule
`default_nettype wire
